// file: pet_pkg.sv
// pet_pkg: register map, field positions, reset values and states of the enable/trim register bank
package pet_pkg;

   // =====================================================================
   // register offsets
   localparam logic [7:0] ADDR_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_TRIM = 8'h01;
   localparam logic [7:0] ADDR_STAT1 = 8'h02;
   localparam logic [7:0] ADDR_STAT2 = 8'h03;

   // =====================================================================
   // reset values
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_TRIM = 8'h00;
   localparam logic [7:0] RST_STAT1 = 8'h00;
   localparam logic [2:0] RST_UV = 3'h0;

   // =====================================================================
   // field positions
   localparam int TRIM_SEL_BIT = 5;
   localparam int REG_ON_LSB = 2;
   localparam int USB_ON_LSB = 0;
   localparam int REG2_TRIM_LSB = 2;
   localparam int REG3_TRIM_LSB = 0;
   localparam logic [1:0] TRIM_NOMINAL = 2'h0;
   localparam logic [1:0] STAT2_UNUSED = 2'h0;

   // =====================================================================
   // serial bus
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A; // arbitrary value
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_LAST_TX = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ADDR_ACK = 3'h2,
      ST_WR = 3'h3,
      ST_WR_ACK = 3'h4,
      ST_RD = 3'h5,
      ST_RD_ACK = 3'h6
   } pet_bus_state_t;

endpackage : pet_pkg

// file: pet_sync.sv
// pet_sync: two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
module pet_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // =====================================================================
   // per bit: first stage feeds only the second stage
   // resets low, so a line that idles high has to arrive inverted
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end else begin
               meta_r <= async_in[i];
               sync_r <= meta_r;
            end
         end
         assign sync_out[i] = sync_r;
      end
   endgenerate

endmodule : pet_sync

// file: pet_regbank.sv
// pet_regbank: serial-bus slave with enable, trim and status registers of the power controller
`timescale 1ns/10ps
module pet_regbank #(
   parameter logic [6:0] DEV_ADDR = pet_pkg::DEV_ADDR_DFLT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial bus, sda open drain
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // external enable and trim select pins
   input wire logic regulator_one_en_pin,
   input wire logic regulator_two_en_pin,
   input wire logic regulator_three_en_pin,
   input wire logic trim_select_pin,
   // analog monitors
   input wire logic [7:0] fault_event,
   input wire logic [2:0] undervoltage_event,
   input wire logic [2:0] power_good,
   // rail controls
   output logic regulator_one_on,
   output logic regulator_two_on,
   output logic regulator_three_on,
   output logic usb_switch_one_on,
   output logic usb_switch_two_on,
   output logic [1:0] regulator_two_trim,
   output logic [1:0] regulator_three_trim,
   // interrupt, open drain
   output logic int_out,
   output logic int_oe_n
);

   // =====================================================================
   // input synchronisation
   logic [19:0] raw_in;
   logic [19:0] sync_in;
   // bus inverted: zero reset reads as idle bus, never as fault events or pin enables
   assign raw_in = {~scl, ~sda_in, regulator_one_en_pin, regulator_two_en_pin, regulator_three_en_pin,
                    trim_select_pin, fault_event, undervoltage_event, power_good};

   pet_sync #(.W(20)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   wire scl_s = ~sync_in[19];
   wire sda_s = ~sync_in[18];
   wire [2:0] en_pin_s = sync_in[17:15];
   wire trim_pin_s = sync_in[14];
   wire [7:0] evt_s = sync_in[13:6];
   wire [2:0] uv_s = sync_in[5:3];
   wire [2:0] pg_s = sync_in[2:0];

   // =====================================================================
   // bus edge and condition detection
   logic scl_d_r;
   logic sda_d_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // =====================================================================
   // registers
   logic [7:0] ctl_r;
   logic [7:0] trim_r;
   logic [7:0] stat1_r;
   logic [2:0] uv_r;
   logic [7:0] ptr_r;
   logic [7:0] shift_r;

   wire [7:0] stat2_view = {pet_pkg::STAT2_UNUSED, uv_r, pg_s};
   wire [7:0] rd_data = (ptr_r == pet_pkg::ADDR_ENABLE) ? ctl_r :
                        (ptr_r == pet_pkg::ADDR_TRIM) ? trim_r :
                        (ptr_r == pet_pkg::ADDR_STAT1) ? stat1_r :
                        (ptr_r == pet_pkg::ADDR_STAT2) ? stat2_view : 8'h00;

   // =====================================================================
   // bus state machine
   pet_pkg::pet_bus_state_t state_r, state_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] shift_nxt, ptr_nxt;
   logic first_r, first_nxt;
   logic rw_r, rw_nxt;
   logic drv_r, drv_nxt;
   logic wr_stb;
   logic load_stb;

   always_comb begin
      state_nxt = state_r;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      ptr_nxt = ptr_r;
      first_nxt = first_r;
      rw_nxt = rw_r;
      drv_nxt = drv_r;
      wr_stb = 1'b0;
      load_stb = 1'b0;
      if (start_det) begin
         state_nxt = pet_pkg::ST_ADDR;
         bit_nxt = 4'h0;
         drv_nxt = 1'b0;
      end else if (stop_det) begin
         state_nxt = pet_pkg::ST_IDLE;
         drv_nxt = 1'b0;
      end else begin
         case (state_r)
            pet_pkg::ST_ADDR, pet_pkg::ST_WR: begin
               if (scl_rise && bit_r != pet_pkg::BITS_PER_BYTE) begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  bit_nxt = bit_r + 4'h1;
               end else if (scl_fall && bit_r == pet_pkg::BITS_PER_BYTE) begin
                  if (state_r == pet_pkg::ST_WR) begin
                     state_nxt = pet_pkg::ST_WR_ACK;
                     drv_nxt = 1'b1;
                     wr_stb = 1'b1;
                     first_nxt = 1'b0;
                     ptr_nxt = first_r ? shift_r : ptr_r + 8'h01;
                  end else if (shift_r[7:1] == DEV_ADDR) begin
                     state_nxt = pet_pkg::ST_ADDR_ACK;
                     drv_nxt = 1'b1;
                     rw_nxt = shift_r[0];
                     first_nxt = 1'b1;
                  end else begin
                     state_nxt = pet_pkg::ST_IDLE;
                  end
               end
            end
            pet_pkg::ST_ADDR_ACK, pet_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  bit_nxt = 4'h0;
                  if (state_r == pet_pkg::ST_ADDR_ACK && rw_r) begin
                     state_nxt = pet_pkg::ST_RD;
                     load_stb = 1'b1;
                     shift_nxt = rd_data;
                     drv_nxt = ~rd_data[7];
                     ptr_nxt = ptr_r + 8'h01;
                  end else begin
                     state_nxt = pet_pkg::ST_WR;
                     drv_nxt = 1'b0;
                  end
               end
            end
            pet_pkg::ST_RD: begin
               if (scl_fall) begin
                  if (bit_r == pet_pkg::BIT_LAST_TX) begin
                     state_nxt = pet_pkg::ST_RD_ACK;
                     drv_nxt = 1'b0;
                  end else begin
                     bit_nxt = bit_r + 4'h1;
                     shift_nxt = {shift_r[6:0], 1'b0};
                     drv_nxt = ~shift_r[6];
                  end
               end
            end
            pet_pkg::ST_RD_ACK: begin
               // a nack ends the read; the master then sends stop or restart
               if (scl_rise && sda_s) begin
                  state_nxt = pet_pkg::ST_IDLE;
               end else if (scl_fall) begin
                  state_nxt = pet_pkg::ST_RD;
                  bit_nxt = 4'h0;
                  load_stb = 1'b1;
                  shift_nxt = rd_data;
                  drv_nxt = ~rd_data[7];
                  ptr_nxt = ptr_r + 8'h01;
               end
            end
            default: begin
               state_nxt = pet_pkg::ST_IDLE;
               drv_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= pet_pkg::ST_IDLE;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         first_r <= 1'b0;
         rw_r <= 1'b0;
         drv_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
         ptr_r <= ptr_nxt;
         first_r <= first_nxt;
         rw_r <= rw_nxt;
         drv_r <= drv_nxt;
      end
   end

   // =====================================================================
   // register writes and status flags
   wire wr_data = wr_stb & ~first_r;
   wire wr_ctl = wr_data & (ptr_r == pet_pkg::ADDR_ENABLE);
   wire wr_trim = wr_data & (ptr_r == pet_pkg::ADDR_TRIM);
   wire clr_stat1 = load_stb & (ptr_r == pet_pkg::ADDR_STAT1);
   wire clr_stat2 = load_stb & (ptr_r == pet_pkg::ADDR_STAT2);
   // a monitor event in the clearing cycle survives the clear
   wire [7:0] stat1_nxt = (stat1_r & ~{8{clr_stat1}}) | evt_s;
   wire [2:0] uv_nxt = (uv_r & ~{3{clr_stat2}}) | uv_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_r <= pet_pkg::RST_ENABLE;
         trim_r <= pet_pkg::RST_TRIM;
         stat1_r <= pet_pkg::RST_STAT1;
         uv_r <= pet_pkg::RST_UV;
      end else begin
         if (wr_ctl) ctl_r <= shift_r;
         if (wr_trim) trim_r <= shift_r;
         stat1_r <= stat1_nxt;
         uv_r <= uv_nxt;
      end
   end

   // =====================================================================
   // rail controls
   wire trim_act = ctl_r[pet_pkg::TRIM_SEL_BIT] | trim_pin_s;
   logic [2:0] reg_on_r;
   logic [1:0] usb_on_r;
   logic [1:0] r2_trim_r;
   logic [1:0] r3_trim_r;
   logic int_oe_n_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_on_r <= 3'h0;
         usb_on_r <= 2'h0;
         r2_trim_r <= pet_pkg::TRIM_NOMINAL;
         r3_trim_r <= pet_pkg::TRIM_NOMINAL;
         int_oe_n_r <= 1'b1;
      end else begin
         reg_on_r <= ctl_r[pet_pkg::REG_ON_LSB +: 3] | en_pin_s;
         usb_on_r <= ctl_r[pet_pkg::USB_ON_LSB +: 2];
         r2_trim_r <= trim_act ? trim_r[pet_pkg::REG2_TRIM_LSB +: 2] : pet_pkg::TRIM_NOMINAL;
         r3_trim_r <= trim_act ? trim_r[pet_pkg::REG3_TRIM_LSB +: 2] : pet_pkg::TRIM_NOMINAL;
         int_oe_n_r <= ~(|stat1_r | |uv_r);
      end
   end

   assign regulator_one_on = reg_on_r[2];
   assign regulator_two_on = reg_on_r[1];
   assign regulator_three_on = reg_on_r[0];
   assign usb_switch_one_on = usb_on_r[1];
   assign usb_switch_two_on = usb_on_r[0];
   assign regulator_two_trim = r2_trim_r;
   assign regulator_three_trim = r3_trim_r;
   assign sda_out = 1'b0;
   assign sda_oe_n = ~drv_r;
   assign int_out = 1'b0;
   assign int_oe_n = int_oe_n_r;

   // =====================================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ctl_write;
      wr_ctl |=> ctl_r == $past(shift_r);
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("enable register not written");

   property p_trim_write;
      wr_trim |=> trim_r == $past(shift_r);
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim register not written");

   property p_trim_gate;
      ##1 r2_trim_r == ($past(trim_act) ? $past(trim_r[3:2]) : 2'h0);
   endproperty
   a_trim_gate: assert property (p_trim_gate) else $error("regulator two trim wrong");

   property p_trim3;
      ##1 r3_trim_r == ($past(trim_act) ? $past(trim_r[1:0]) : 2'h0);
   endproperty
   a_trim3: assert property (p_trim3) else $error("regulator three trim wrong");

   property p_reg_on;
      ##1 reg_on_r == ($past(ctl_r[4:2]) | $past(en_pin_s));
   endproperty
   a_reg_on: assert property (p_reg_on) else $error("regulator enable not bit or pin");

   property p_usb_on;
      ##1 usb_on_r == $past(ctl_r[1:0]);
   endproperty
   a_usb_on: assert property (p_usb_on) else $error("usb switch enable wrong");

   property p_stat1_rc;
      clr_stat1 |=> stat1_r == $past(evt_s) && shift_r == $past(stat1_r);
   endproperty
   a_stat1_rc: assert property (p_stat1_rc) else $error("first status not cleared on read");

   property p_stat2_rc;
      clr_stat2 |=> uv_r == $past(uv_s) && shift_r[2:0] == $past(pg_s);
   endproperty
   a_stat2_rc: assert property (p_stat2_rc) else $error("second status read wrong");

   sequence s_flags_clear;
      stat1_r == 8'h00 && uv_r == 3'h0;
   endsequence
   property p_int_release;
      s_flags_clear |=> int_oe_n;
   endproperty
   a_int_release: assert property (p_int_release) else $error("interrupt held with no flags");

   property p_unmapped;
      (wr_data && ptr_r > pet_pkg::ADDR_STAT2) |=> $stable(ctl_r) && $stable(trim_r);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("write above map changed a register");

endmodule : pet_regbank

// file: pet_host.sv
// pet_host: serial bus controller model standing in for the host processor
`timescale 1ns/10ps
module pet_host (
   // clock
   input wire logic clk,
   // serial bus
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   // bus clock idles high between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt

   // ======================================================
   // bit level: 8 system clocks per bus clock
   // data moves mid low phase, sampled mid high phase
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      wt(2);
      sda_low = ~b;
      wt(2);
      scl = 1'b1;
      wt(2);
      s = sda;
      wt(2);
   endtask : bit_io

   // serves from idle and as a repeated start
   task automatic start();
      scl = 1'b0;
      wt(2);
      sda_low = 1'b0;
      wt(2);
      scl = 1'b1;
      wt(4);
      sda_low = 1'b1;
      wt(4);
   endtask : start

   task automatic stop();
      scl = 1'b0;
      wt(2);
      sda_low = 1'b1;
      wt(2);
      scl = 1'b1;
      wt(4);
      sda_low = 1'b0;
      wt(8);
   endtask : stop

   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : send

   // more high: host acknowledges and the read goes on
   task automatic recv(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~more, s);
   endtask : recv
endmodule : pet_host

// file: pet_regbank_tb.sv
// pet_regbank_tb: self-checking bench for the enable and trim register bank
`timescale 1ns/10ps
module pet_regbank_tb;
   localparam logic [6:0] DEV = 7'h15;
   logic clk;
   logic rst;
   logic scl;
   logic sda_low;
   logic sda_out;
   logic sda_oe_n;
   logic [2:0] en_pin;
   logic trim_pin;
   logic [7:0] fault;
   logic [2:0] uv;
   logic [2:0] pg;
   logic r1, r2, r3, u1, u2;
   logic [1:0] t2, t3;
   logic int_out;
   logic int_oe_n;
   logic [7:0] d;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // sda has a pull-up, either party may pull it low
   wire sda = (sda_low || (sda_oe_n === 1'b0 && sda_out === 1'b0)) ? 1'b0 : 1'b1;
   wire [7:0] rails = {3'h0, r1, r2, r3, u1, u2};
   wire [7:0] trims = {4'h0, t2, t3};

   pet_regbank #(.DEV_ADDR(DEV)) u_pet_regbank (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .regulator_one_en_pin(en_pin[2]),
      .regulator_two_en_pin(en_pin[1]), .regulator_three_en_pin(en_pin[0]), .trim_select_pin(trim_pin),
      .fault_event(fault), .undervoltage_event(uv), .power_good(pg), .regulator_one_on(r1),
      .regulator_two_on(r2), .regulator_three_on(r3), .usb_switch_one_on(u1), .usb_switch_two_on(u2),
      .regulator_two_trim(t2), .regulator_three_trim(t3), .int_out(int_out), .int_oe_n(int_oe_n));

   pet_host u_pet_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ======================================================
   // helpers
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
      logic a0, a1, a2;
      u_pet_host.start();
      u_pet_host.send({DEV, 1'b0}, a0);
      u_pet_host.send(ptr, a1);
      u_pet_host.send(v, a2);
      u_pet_host.stop();
      check({5'h0, a0, a1, a2}, 8'h07, "write acks");
   endtask : wr

   task automatic rd(input logic [7:0] ptr, output logic [7:0] v);
      logic a0, a1, a2;
      u_pet_host.start();
      u_pet_host.send({DEV, 1'b0}, a0);
      u_pet_host.send(ptr, a1);
      u_pet_host.start();
      u_pet_host.send({DEV, 1'b1}, a2);
      u_pet_host.recv(1'b0, v);
      u_pet_host.stop();
      check({5'h0, a0, a1, a2}, 8'h07, "read acks");
   endtask : rd

   // ======================================================
   // scenarios
   task automatic t_reset();
      for (int a = 0; a < 4; a++) begin
         rd(8'(a), d);
         check(d, 8'h00, "reset value");
      end
      check(rails | trims, 8'h00, "outputs after reset");
   endtask : t_reset

   task automatic t_enable();
      wr(pet_pkg::ADDR_ENABLE, 8'hFF);
      rd(pet_pkg::ADDR_ENABLE, d);
      check(d, 8'hFF, "enable readback");
      for (int b = 0; b < 5; b++) begin
         wr(pet_pkg::ADDR_ENABLE, 8'(8'h01 << b));
         check(rails, 8'(8'h01 << b), "rail control");
      end
   endtask : t_enable

   task automatic t_or_pin();
      wr(pet_pkg::ADDR_ENABLE, 8'h00);
      for (int b = 0; b < 3; b++) begin
         en_pin = 3'(3'h1 << b);
         wt(6);
         check(rails, 8'(8'h04 << b), "pin enable");
      end
      en_pin = 3'h0;
      wt(6);
      check(rails, 8'h00, "pin release");
   endtask : t_or_pin

   task automatic t_trim();
      wr(pet_pkg::ADDR_TRIM, 8'hFF);
      rd(pet_pkg::ADDR_TRIM, d);
      check(d, 8'hFF, "trim readback");
      check(trims, 8'h00, "trim unselected");
      wr(pet_pkg::ADDR_ENABLE, 8'h20);
      check(trims, 8'h0F, "trim selected");
      for (int c = 0; c < 4; c++) begin
         wr(pet_pkg::ADDR_TRIM, 8'(c * 4 + 3 - c));
         check(trims, 8'(c * 4 + 3 - c), "trim codes");
      end
      wr(pet_pkg::ADDR_ENABLE, 8'h00);
      check(trims, 8'h00, "trim bit cleared");
      trim_pin = 1'b1;
      wt(6);
      check(trims, 8'h0C, "trim by pin");
      trim_pin = 1'b0;
      wt(6);
      check(trims, 8'h00, "trim pin released");
   endtask : t_trim

   task automatic t_status();
      fault = 8'hA5;
      uv = 3'h5;
      pg = 3'h3;
      wt(6);
      fault = 8'h00;
      uv = 3'h0;
      wt(4);
      check({7'h0, int_oe_n}, 8'h00, "interrupt on");
      rd(pet_pkg::ADDR_STAT1, d);
      check(d, 8'hA5, "first status");
      rd(pet_pkg::ADDR_STAT1, d);
      check(d, 8'h00, "first status cleared");
      check({7'h0, int_oe_n}, 8'h00, "interrupt held");
      rd(pet_pkg::ADDR_STAT2, d);
      check(d, 8'h2B, "second status");
      rd(pet_pkg::ADDR_STAT2, d);
      check(d, 8'h03, "second status cleared");
      check({7'h0, int_oe_n}, 8'h01, "interrupt released");
      check({6'h0, sda_out, int_out}, 8'h00, "open drain drive levels");
      pg = 3'h0;
   endtask : t_status

   task automatic t_burst();
      logic a0, a1, a2, a3;
      logic [7:0] v0, v1;
      u_pet_host.start();
      u_pet_host.send({DEV, 1'b0}, a0);
      u_pet_host.send(pet_pkg::ADDR_ENABLE, a1);
      u_pet_host.send(8'h14, a2);
      u_pet_host.send(8'h09, a3);
      u_pet_host.stop();
      check({4'h0, a0, a1, a2, a3}, 8'h0F, "burst write acks");
      check(rails, 8'h14, "burst enable");
      check(trims, 8'h00, "burst trim unselected");
      u_pet_host.start();
      u_pet_host.send({DEV, 1'b0}, a0);
      u_pet_host.send(pet_pkg::ADDR_ENABLE, a1);
      u_pet_host.start();
      u_pet_host.send({DEV, 1'b1}, a2);
      u_pet_host.recv(1'b1, v0);
      u_pet_host.recv(1'b0, v1);
      u_pet_host.stop();
      check({5'h0, a0, a1, a2}, 8'h07, "burst read acks");
      check(v0, 8'h14, "burst enable readback");
      check(v1, 8'h09, "burst trim readback");
   endtask : t_burst

   task automatic t_mid_reset();
      wr(pet_pkg::ADDR_ENABLE, 8'hFF);
      rst = 1'b1;
      wt(4);
      rst = 1'b0;
      wt(2);
      check(rails | trims, 8'h00, "outputs after mid-run reset");
      wt(6);
      rd(pet_pkg::ADDR_ENABLE, d);
      check(d, 8'h00, "enable after mid-run reset");
      rd(pet_pkg::ADDR_STAT1, d);
      check(d, 8'h00, "first status after mid-run reset");
   endtask : t_mid_reset

   task automatic t_unmapped();
      logic a;
      wr(8'h04, 8'h55);
      rd(8'h04, d);
      check(d, 8'h00, "unmapped read");
      rd(pet_pkg::ADDR_ENABLE, d);
      check(d, 8'h00, "enable untouched");
      rd(pet_pkg::ADDR_TRIM, d);
      check(d, 8'h0C, "trim untouched");
      // a foreign address must be left unanswered
      u_pet_host.start();
      u_pet_host.send({DEV ^ 7'h01, 1'b0}, a);
      u_pet_host.stop();
      check({7'h0, a}, 8'h00, "foreign address");
   endtask : t_unmapped

   // ======================================================
   // verdict and run control
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // whole run needs about 9700 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         $display("ERROR at %0t: run timed out", $time);
         print_verdict();
      end
   end

   initial begin
      rst = 1'b1;
      en_pin = 3'h0;
      trim_pin = 1'b0;
      fault = 8'h00;
      uv = 3'h0;
      pg = 3'h0;
      wt(4);
      rst = 1'b0;
      wt(8);
      t_reset();
      t_enable();
      t_or_pin();
      t_trim();
      t_status();
      t_unmapped();
      t_burst();
      t_mid_reset();
      print_verdict();
   end
endmodule : pet_regbank_tb
